// [rtl/fwp_consts.svh]
// Constants of the flash write-protection and status block
`ifndef FWP_CONSTS_SVH
`define FWP_CONSTS_SVH

// Instruction codes
`define FWP_OP_WR_ENABLE 8'h06
`define FWP_OP_WR_DISABLE 8'h04
`define FWP_OP_RD_STATUS 8'h05
`define FWP_OP_WR_STATUS 8'h01
`define FWP_OP_PROGRAM 8'h02
`define FWP_OP_ERASE_4K 8'h20
`define FWP_OP_ERASE_32K 8'h52
`define FWP_OP_ERASE_64K 8'hd8
`define FWP_OP_ERASE_ALL 8'hc7
`define FWP_OP_ERASE_ALL2 8'h60
`define FWP_OP_POWER_DOWN 8'hb9
`define FWP_OP_RELEASE 8'hab

// Status byte positions
`define FWP_ST_BUSY 0
`define FWP_ST_WEL 1
`define FWP_ST_LVL_LO 2
`define FWP_ST_SIDE 5
`define FWP_ST_RSVD 6
`define FWP_ST_LOCK 7
`define FWP_ST_RESET 8'h00

// Byte counts of accepted frames
`define FWP_BYTES_STATUS 3'd2
`define FWP_BYTES_ADDR 3'd4

// Address map of the array and the protected ranges
`define FWP_ARRAY_TOP 24'h07ffff
`define FWP_TOP_LO_1 24'h070000
`define FWP_TOP_LO_2 24'h060000
`define FWP_TOP_LO_3 24'h040000
`define FWP_BOT_HI_1 24'h00ffff
`define FWP_BOT_HI_2 24'h01ffff
`define FWP_BOT_HI_3 24'h03ffff
`define FWP_MASK_PAGE 24'h0000ff
`define FWP_MASK_4K 24'h000fff
`define FWP_MASK_32K 24'h007fff
`define FWP_MASK_64K 24'h00ffff

// Timing
`define FWP_CLK_MHZ 50
`define FWP_PUW_US 1000
`define FWP_PUW_CYC (`FWP_PUW_US * `FWP_CLK_MHZ)
`define FWP_TW_NS 10000
`define FWP_TW_CYC ((`FWP_TW_NS * `FWP_CLK_MHZ + 999) / 1000)

`endif

// [rtl/fwp_pkg.sv]
// Types of the flash write-protection and status block
package fwp_pkg;
  // Internal cycle state, one bit flips on idle-status and idle-array
  typedef enum logic [1:0] {
    FWP_IDLE = 2'b00,
    FWP_WSR = 2'b01,
    FWP_ARRAY = 2'b10
  } fwp_state_t;

  // Array operation handed to the datapath
  typedef enum logic [2:0] {
    FWP_AOP_PROGRAM = 3'h0,
    FWP_AOP_ERASE_4K = 3'h1,
    FWP_AOP_ERASE_32K = 3'h2,
    FWP_AOP_ERASE_64K = 3'h3,
    FWP_AOP_ERASE_ALL = 3'h4
  } fwp_arr_op_t;
endpackage

// [rtl/fwp_sync.sv]
// Two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module fwp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// [rtl/fwp_range.sv]
// Protected-range decode and region overlap test
`timescale 1ns/1ps
`default_nettype none
`include "fwp_consts.svh"
module fwp_range import fwp_pkg::*; (
  // Protection setting
  input wire logic [2:0] level,
  input wire logic side,
  // Target region
  input wire logic [23:0] first,
  input wire logic [23:0] last,
  output logic hit
);
  logic [23:0] top_lo;
  logic [23:0] bot_hi;
  logic [23:0] prot_lo;
  logic [23:0] prot_hi;
  logic any;

  // Range grows from the top or from the bottom
  assign top_lo = (level[1:0] == 2'h1) ? `FWP_TOP_LO_1 :
                  (level[1:0] == 2'h2) ? `FWP_TOP_LO_2 : `FWP_TOP_LO_3;
  assign bot_hi = (level[1:0] == 2'h1) ? `FWP_BOT_HI_1 :
                  (level[1:0] == 2'h2) ? `FWP_BOT_HI_2 : `FWP_BOT_HI_3;
  assign any = (level != 3'h0);
  assign prot_lo = (level[2] || side) ? 24'h000000 : top_lo;
  assign prot_hi = (level[2] || !side) ? `FWP_ARRAY_TOP : bot_hi;
  // Any overlap blocks the whole operation
  assign hit = any && (first <= prot_hi) && (last >= prot_lo);
endmodule
`default_nettype wire

// [rtl/fwp_top.sv]
// Write protection, status register and power-down lockout
`timescale 1ns/1ps
`default_nettype none
`include "fwp_consts.svh"
module fwp_top import fwp_pkg::*; #(
  parameter int PUW_CYC = `FWP_PUW_CYC,
  parameter int TW_CYC = `FWP_TW_CYC
) (
  // System clock and supply-threshold reset
  input wire logic mclk,
  input wire logic arst_n,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic di,
  output logic spi_do,
  output logic spi_do_oe,
  // Write-protect pin
  input wire logic wp_n,
  // Array datapath
  output logic arr_start,
  output fwp_arr_op_t arr_op,
  output logic [23:0] arr_addr,
  input wire logic arr_done,
  // Observation
  output logic [7:0] status,
  output logic power_down
);
  localparam int PW = $clog2(PUW_CYC + 1);
  localparam int TWW = $clog2(TW_CYC + 1);

  // ---------------- Link side, on the serial clock ----------------
  logic frame_clr;
  logic [2:0] bit_pos;
  logic [2:0] byte_cnt;
  logic [6:0] shin;
  logic [7:0] in_byte;
  logic rd_active;
  logic frame_id;
  logic [2:0] nbytes;
  logic aligned;
  logic [7:0] opc;
  logic [23:0] addr;
  logic [7:0] wsr_data;
  logic [8:0] stat_s;
  logic [2:0] out_pos;
  logic [6:0] out_sh;

  // Deselect or supply reset clears the bit, byte, shift and read-out state
  assign frame_clr = cs_n || !arst_n;
  assign in_byte = {shin, di};

  // Status and power-down flag crossed into the link domain
  fwp_sync #(.W(9)) u_stat_sync (
    .clk(sclk),
    .arst_n(arst_n),
    .d({power_down, status}),
    .q(stat_s)
  );

  // Bit and byte position inside the frame
  always_ff @(posedge sclk or posedge frame_clr) begin
    if (frame_clr) begin
      bit_pos <= 3'h0;
      byte_cnt <= 3'h0;
      shin <= 7'h00;
      rd_active <= 1'b0;
    end else begin
      bit_pos <= bit_pos + 3'h1;
      shin <= in_byte[6:0];
      if (bit_pos == 3'h7 && byte_cnt != 3'h7) begin
        byte_cnt <= byte_cnt + 3'h1;
      end
      // Read status never starts in power-down
      if (bit_pos == 3'h7 && byte_cnt == 3'h0 && !stat_s[8] &&
          in_byte == `FWP_OP_RD_STATUS) begin
        rd_active <= 1'b1;
      end
    end
  end

  // Frame fields survive deselect so the system side can read them
  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      frame_id <= 1'b0;
      nbytes <= 3'h0;
      aligned <= 1'b0;
      opc <= 8'h00;
      addr <= 24'h000000;
      wsr_data <= 8'h00;
    end else begin
      if (bit_pos == 3'h0 && byte_cnt == 3'h0) begin
        frame_id <= ~frame_id;
      end
      aligned <= (bit_pos == 3'h7);
      if (bit_pos == 3'h7) begin
        nbytes <= (byte_cnt == 3'h7) ? byte_cnt : byte_cnt + 3'h1;
        case (byte_cnt)
          3'h0: opc <= in_byte;
          3'h1: begin
            addr[23:16] <= in_byte;
            wsr_data <= in_byte;
          end
          3'h2: addr[15:8] <= in_byte;
          3'h3: addr[7:0] <= in_byte;
          default: addr <= addr;
        endcase
      end
    end
  end

  // Status shifts out MSB first, reloaded every byte so busy stays live
  always_ff @(negedge sclk or posedge frame_clr) begin
    if (frame_clr) begin
      out_pos <= 3'h0;
      out_sh <= 7'h00;
      spi_do <= 1'b0;
      spi_do_oe <= 1'b0;
    end else if (rd_active) begin
      spi_do_oe <= 1'b1;
      out_pos <= out_pos + 3'h1;
      if (out_pos == 3'h0) begin
        {spi_do, out_sh} <= stat_s[7:0];
      end else begin
        {spi_do, out_sh} <= {out_sh, 1'b0};
      end
    end
  end

  // ---------------- System side, on mclk ----------------
  logic sel_s;
  logic wp_s;
  logic sel_prev;
  logic seen_id;
  logic frame_end;
  logic new_frame;
  fwp_state_t state;
  logic write_enable_latch;
  logic busy;
  logic lock;
  logic side;
  logic [2:0] level;
  logic [7:0] pend;
  logic [PW-1:0] puw_cnt;
  logic puw_done;
  logic [TWW-1:0] tw_cnt;
  logic tw_end;

  // Pins crossed into the system domain; select goes across inverted so
  // the flops' reset value means deselected and no false end follows reset
  fwp_sync #(.W(2)) u_pin_sync (
    .clk(mclk),
    .arst_n(arst_n),
    .d({~cs_n, wp_n}),
    .q({sel_s, wp_s})
  );

  // Frame fields are still while deselected, so they are read at the
  // synchronised falling edge of select; a frame with no clock edge
  // leaves the frame id unchanged and is ignored
  assign frame_end = !sel_s && sel_prev;
  assign new_frame = frame_end && (frame_id != seen_id);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sel_prev <= 1'b0;
      seen_id <= 1'b0;
    end else begin
      sel_prev <= sel_s;
      if (frame_end) begin
        seen_id <= frame_id;
      end
    end
  end

  // Power-up write delay counter
  assign puw_done = (puw_cnt == PW'(PUW_CYC));
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      puw_cnt <= '0;
    end else if (!puw_done) begin
      puw_cnt <= puw_cnt + 1'b1;
    end
  end

  // Opcode decode
  logic is_wen;
  logic is_wdi;
  logic is_wsr;
  logic is_pd;
  logic is_rel;
  logic is_ce;
  logic is_arr;
  logic [23:0] mask;
  logic [23:0] reg_first;
  logic [23:0] reg_last;
  logic prot_hit;
  fwp_arr_op_t next_op;

  assign is_wen = (opc == `FWP_OP_WR_ENABLE);
  assign is_wdi = (opc == `FWP_OP_WR_DISABLE);
  assign is_wsr = (opc == `FWP_OP_WR_STATUS);
  assign is_pd = (opc == `FWP_OP_POWER_DOWN);
  assign is_rel = (opc == `FWP_OP_RELEASE);
  assign is_ce = (opc == `FWP_OP_ERASE_ALL) ||
                 (opc == `FWP_OP_ERASE_ALL2);

  // Region size and array operation from the opcode
  assign is_arr = is_ce || (opc == `FWP_OP_PROGRAM) ||
                  (opc == `FWP_OP_ERASE_4K) ||
                  (opc == `FWP_OP_ERASE_32K) ||
                  (opc == `FWP_OP_ERASE_64K);
  assign mask = is_ce ? `FWP_ARRAY_TOP :
                (opc == `FWP_OP_PROGRAM) ? `FWP_MASK_PAGE :
                (opc == `FWP_OP_ERASE_4K) ? `FWP_MASK_4K :
                (opc == `FWP_OP_ERASE_32K) ? `FWP_MASK_32K :
                `FWP_MASK_64K;
  assign next_op = is_ce ? FWP_AOP_ERASE_ALL :
                   (opc == `FWP_OP_PROGRAM) ? FWP_AOP_PROGRAM :
                   (opc == `FWP_OP_ERASE_4K) ? FWP_AOP_ERASE_4K :
                   (opc == `FWP_OP_ERASE_32K) ? FWP_AOP_ERASE_32K :
                   FWP_AOP_ERASE_64K;
  // Whole region, not only the start address, is tested
  assign reg_first = is_ce ? 24'h000000 : (addr & ~mask);
  assign reg_last = is_ce ? `FWP_ARRAY_TOP : (addr | mask);

  fwp_range u_range (
    .level(level),
    .side(side),
    .first(reg_first),
    .last(reg_last),
    .hit(prot_hit)
  );

  // Acceptance of each instruction at frame end
  logic op_ok;
  logic wen_go;
  logic wdi_go;
  logic wsr_go;
  logic arr_go;
  logic pd_go;
  logic rel_go;
  logic wsr_locked;

  assign busy = (state != FWP_IDLE);
  assign op_ok = new_frame && aligned && !busy && !power_down;
  assign wsr_locked = lock && !wp_s;
  assign wen_go = op_ok && is_wen && puw_done;
  assign wdi_go = op_ok && is_wdi;
  assign wsr_go = op_ok && is_wsr && write_enable_latch && puw_done && !wsr_locked &&
                  (nbytes >= `FWP_BYTES_STATUS);
  assign arr_go = op_ok && is_arr && write_enable_latch && puw_done && !prot_hit &&
                  (is_ce || nbytes >= `FWP_BYTES_ADDR);
  assign pd_go = op_ok && is_pd;
  assign rel_go = new_frame && is_rel && !busy;
  assign tw_end = (tw_cnt == TWW'(TW_CYC - 1));

  // Internal cycle sequencing
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= FWP_IDLE;
      tw_cnt <= '0;
      pend <= 8'h00;
      arr_start <= 1'b0;
      arr_op <= FWP_AOP_PROGRAM;
      arr_addr <= 24'h000000;
    end else begin
      arr_start <= 1'b0;
      case (state)
        FWP_IDLE: begin
          tw_cnt <= '0;
          if (wsr_go) begin
            pend <= wsr_data;
            state <= FWP_WSR;
          end else if (arr_go) begin
            arr_start <= 1'b1;
            arr_op <= next_op;
            arr_addr <= reg_first;
            state <= FWP_ARRAY;
          end
        end
        FWP_WSR: begin
          tw_cnt <= tw_cnt + 1'b1;
          if (tw_end) begin
            state <= FWP_IDLE;
          end
        end
        FWP_ARRAY: begin
          if (arr_done) begin
            state <= FWP_IDLE;
          end
        end
        default: state <= FWP_IDLE;
      endcase
    end
  end

  // Protection bits take the new value only as the status cycle ends
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lock <= 1'b0;
      side <= 1'b0;
      level <= 3'h0;
    end else if (state == FWP_WSR && tw_end) begin
      lock <= pend[`FWP_ST_LOCK];
      side <= pend[`FWP_ST_SIDE];
      level <= pend[`FWP_ST_LVL_LO +: 3];
    end
  end

  // Write-enable latch; a set can never meet a finish since busy blocks it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      write_enable_latch <= 1'b0;
    end else if (wen_go) begin
      write_enable_latch <= 1'b1;
    end else if (wdi_go || (state == FWP_WSR && tw_end) ||
                 (state == FWP_ARRAY && arr_done)) begin
      write_enable_latch <= 1'b0;
    end
  end

  // Power-down lockout
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      power_down <= 1'b0;
    end else if (rel_go) begin
      power_down <= 1'b0;
    end else if (pd_go) begin
      power_down <= 1'b1;
    end
  end

  // Status byte; reserved position is a constant zero
  assign status = {lock, 1'b0, side, level, write_enable_latch, busy};

  // ---------------- Checks ----------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  puw_wen_block_a: assert property (
    (new_frame && is_wen && !puw_done && !write_enable_latch) |=> !write_enable_latch)
    else $error("write enable taken during power-up delay");
  wen_sets_a: assert property (
    wen_go |=> write_enable_latch && status[`FWP_ST_WEL])
    else $error("write enable did not set latch");
  finish_clears_a: assert property (
    (state == FWP_ARRAY && arr_done) |=> !write_enable_latch && !busy)
    else $error("latch or busy not cleared at end of array cycle");
  busy_ignore_a: assert property (
    (busy && new_frame && !(state == FWP_WSR && tw_end)) |=>
    $stable(level) && $stable(power_down) && !arr_start)
    else $error("instruction acted upon while busy");
  lock_reject_a: assert property (
    (new_frame && is_wsr && lock && !wp_s && !busy) |=>
    state == FWP_IDLE)
    else $error("status write accepted while locked");
  prot_block_a: assert property (
    arr_start |-> $past(!prot_hit) && write_enable_latch)
    else $error("array cycle started on protected region");
  wsr_busy_a: assert property (
    (state == FWP_IDLE && wsr_go) |=> busy && $stable(level)
    ##1 busy && $stable(level))
    else $error("status bits changed before end of busy cycle");
  pd_hold_a: assert property (
    (power_down && new_frame && !is_rel) |=>
    power_down && state == FWP_IDLE)
    else $error("instruction acted upon in power-down");
  rsvd_zero_a: assert property (
    $rose(busy) |-> (status[`FWP_ST_RSVD] == 1'b0) [*2])
    else $error("reserved status bit not zero");
endmodule
`default_nettype wire

// [dv/fwp_host.sv]
// Host-side serial link model: command frames and status reads
`timescale 1ns/1ps
`default_nettype none
`include "fwp_consts.svh"
module fwp_host (
  // Link outputs
  output logic sclk,
  output logic cs_n,
  output logic di,
  // Link inputs
  input wire logic spi_do,
  input wire logic spi_do_oe
);
  logic last_bit;

  // Idle: clock stands low, deselected, data line off its last value
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    di = 1'b1;
    last_bit = 1'b0;
  end

  // Send nbits of v MSB first; callers keep write frames byte-whole, except the 7-bit enable frame in t_wel
  task automatic frame(input logic [31:0] v, input int nbits);
    cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      di = v[31 - i];
      last_bit = v[31 - i];
      #16 sclk = 1'b1;
      #16 sclk = 1'b0;
    end
    #16 cs_n = 1'b1;
    di = ~last_bit;
    // Gap long enough for the instruction to act on the far side
    #250;
  endtask

  // Read two status bytes; a bit with the driver off reads unknown
  task automatic read_status(output logic [15:0] r);
    logic [23:0] v;
    v = {`FWP_OP_RD_STATUS, 16'h0000};
    r = 16'h0000;
    cs_n = 1'b0;
    for (int i = 0; i < 24; i++) begin
      di = v[23 - i];
      #16 sclk = 1'b1;
      if (i >= 8) begin
        r[23 - i] = spi_do_oe ? spi_do : 1'bx;
      end
      #16 sclk = 1'b0;
    end
    #16 cs_n = 1'b1;
    di = 1'b1;
    // Reserved position masked so later parts still compare equal
    r = r & 16'hbfbf;
    #250;
  endtask
endmodule
`default_nettype wire

// [dv/fwp_top_tb.sv]
// Self-checking bench of the write-protection and status block
`timescale 1ns/1ps
`default_nettype none
`include "fwp_consts.svh"
module fwp_top_tb import fwp_pkg::*; ;
  localparam int PUW = 200;
  localparam int TW = 150;
  localparam logic [31:0] WREN = {`FWP_OP_WR_ENABLE, 24'h0};
  localparam logic [31:0] WRDI = {`FWP_OP_WR_DISABLE, 24'h0};
  logic mclk, arst_n, wp_n, arr_done;
  wire sclk, cs_n, di, spi_do, spi_do_oe, arr_start, power_down;
  fwp_arr_op_t arr_op;
  wire [23:0] arr_addr;
  wire [7:0] status;
  int fail_count = 0;
  int n_tests = 0;
  int starts = 0;
  fwp_arr_op_t got_op;
  logic [23:0] got_addr;

  fwp_top #(.PUW_CYC(PUW), .TW_CYC(TW)) u_fwp_top (
    .mclk(mclk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .di(di),
    .spi_do(spi_do), .spi_do_oe(spi_do_oe), .wp_n(wp_n),
    .arr_start(arr_start), .arr_op(arr_op), .arr_addr(arr_addr),
    .arr_done(arr_done), .status(status), .power_down(power_down)
  );
  fwp_host u_fwp_host (
    .sclk(sclk), .cs_n(cs_n), .di(di), .spi_do(spi_do),
    .spi_do_oe(spi_do_oe)
  );

  // System clock, 20 ns
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Count array-cycle starts and keep what came with the latest
  always @(posedge mclk) begin
    if (arr_start === 1'b1) begin
      starts <= starts + 1;
      got_op <= arr_op;
      got_addr <= arr_addr;
    end
  end

  task automatic end_of_test();
    if (fail_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  // Frame, then resume just after a clock edge
  task automatic cmd(input logic [31:0] v, input int n);
    u_fwp_host.frame(v, n);
    @(posedge mclk);
    #1;
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while (status[0] !== 1'b0 && k < 4 * TW) begin
      @(posedge mclk);
      #1;
      k++;
    end
    check(k < 4 * TW, "busy never cleared");
  endtask

  // Enable first, or the status write would be refused
  task automatic wsr(input logic [7:0] d);
    cmd(WREN, 8);
    cmd({`FWP_OP_WR_STATUS, d, 16'h0}, 16);
    wait_idle();
  endtask

  task automatic pulse_done();
    @(posedge mclk);
    #1 arr_done = 1'b1;
    @(posedge mclk);
    #1 arr_done = 1'b0;
  endtask

  task automatic t_power_up();
    check(status === `FWP_ST_RESET, "status after reset");
    check(power_down === 1'b0 && spi_do_oe === 1'b0, "idle pins");
    cmd(WREN, 8);
    check(status[1] === 1'b0, "enable taken in delay");
    repeat (PUW) @(posedge mclk);
    #1;
    cmd(WREN, 8);
    check(status === 8'h02, "enable not taken");
  endtask

  task automatic t_wel();
    cmd(WRDI, 8);
    check(status === 8'h00, "disable not taken");
    cmd(WREN, 7);
    check(status[1] === 1'b0, "partial byte taken");
    cmd({`FWP_OP_WR_STATUS, 8'h1c, 16'h0}, 16);
    check(status === 8'h00, "status write without latch");
  endtask

  task automatic t_wsr();
    logic [15:0] rd;
    cmd(WREN, 8);
    cmd({`FWP_OP_WR_STATUS, 8'hfc, 16'h0}, 16);
    check(status[0] === 1'b1, "no busy in write");
    check(status[7:2] === 6'h00, "bits changed early");
    u_fwp_host.read_status(rd);
    check(rd[9:8] === 2'b11, "read while busy");
    cmd(WRDI, 8);
    check(status[1] === 1'b1, "disable taken while busy");
    wait_idle();
    check(status === 8'hbc, "status write result");
    u_fwp_host.read_status(rd);
    check(rd === 16'hbcbc, "serial status");
  endtask

  task automatic t_lock();
    wp_n = 1'b0;
    cmd(WREN, 8);
    cmd({`FWP_OP_WR_STATUS, 8'h00, 16'h0}, 16);
    repeat (8) @(posedge mclk);
    #1;
    check(status[7:2] === 6'h2f && status[0] === 1'b0, "locked");
    cmd(WRDI, 8);
    wp_n = 1'b1;
    wsr(8'h04);
    check(status === 8'h04, "unlocked write");
    wp_n = 1'b0;
  endtask

  // Each setting: erase a protected block, then an open one beside it; 8'h30 has no open block and 8'h20 no protected one
  task automatic t_ranges();
    logic [7:0] sr [8] = '{8'h04, 8'h08, 8'h0c, 8'h24, 8'h28, 8'h2c,
      8'h30, 8'h20};
    logic [23:0] gd [8] = '{24'h060000, 24'h050000, 24'h030000,
      24'h010000, 24'h020000, 24'h040000, 24'hffffff, 24'h000000};
    logic [23:0] bd [8] = '{24'h070000, 24'h060000, 24'h040000,
      24'h000000, 24'h010000, 24'h030000, 24'h070000, 24'hffffff};
    int n;
    for (int i = 0; i < 8; i++) begin
      wsr(sr[i]);
      check(status === sr[i], "setting with pin low");
      if (bd[i] != 24'hffffff) begin
        n = starts;
        cmd(WREN, 8);
        cmd({`FWP_OP_ERASE_64K, bd[i]}, 32);
        check(starts == n && status[0] === 1'b0, "protected erase");
        cmd(WRDI, 8);
      end
      if (gd[i] != 24'hffffff) begin
        n = starts;
        cmd(WREN, 8);
        cmd({`FWP_OP_ERASE_64K, gd[i]}, 32);
        check(starts == n+1 && got_addr === gd[i], "open");
        pulse_done();
        wait_idle();
      end
    end
  endtask

  task automatic t_ops();
    logic [7:0] op [5] = '{8'h02, 8'h20, 8'h52, 8'hc7, 8'h60};
    logic [23:0] ain [5] = '{24'h06ff12, 24'h012345, 24'h01a345,
      24'h000000, 24'h000000};
    logic [23:0] aex [5] = '{24'h06ff00, 24'h012000, 24'h018000,
      24'h000000, 24'h000000};
    fwp_arr_op_t aop [5] = '{FWP_AOP_PROGRAM, FWP_AOP_ERASE_4K,
      FWP_AOP_ERASE_32K, FWP_AOP_ERASE_ALL, FWP_AOP_ERASE_ALL};
    int n;
    for (int i = 0; i < 5; i++) begin
      n = starts;
      cmd(WREN, 8);
      cmd({op[i], ain[i]}, i < 3 ? 32 : 8);
      check(starts == n + 1 && got_op === aop[i], "array op");
      check(got_addr === aex[i], "array region");
      check(status[1:0] === 2'b11, "busy in array cycle");
      cmd(WRDI, 8);
      check(status[1] === 1'b1, "disable taken while busy");
      pulse_done();
      wait_idle();
      check(status[1:0] === 2'b00, "latch after cycle");
    end
  endtask

  task automatic t_power_down();
    cmd({`FWP_OP_POWER_DOWN, 24'h0}, 8);
    check(power_down === 1'b1, "power-down not entered");
    cmd(WREN, 8);
    check(status[1] === 1'b0, "enable in power-down");
    cmd({`FWP_OP_RELEASE, 24'h0}, 8);
    check(power_down === 1'b0, "release not taken");
    cmd(WREN, 8);
    check(status[1] === 1'b1, "enable after release");
  endtask

  // Second reset mid-run; a frame sent during it must do nothing
  task automatic t_reset_mid();
    arst_n = 1'b0;
    u_fwp_host.frame(WREN, 8);
    check(status === 8'h00 && spi_do_oe === 1'b0, "held in reset");
    @(posedge mclk);
    #1 arst_n = 1'b1;
    t_power_up();
  endtask

  initial begin
    arst_n = 1'b0;
    wp_n = 1'b1;
    arr_done = 1'b0;
    repeat (3) @(posedge mclk);
    #1 arst_n = 1'b1;
    t_power_up();
    t_wel();
    t_wsr();
    t_lock();
    t_ranges();
    t_ops();
    t_power_down();
    t_reset_mid();
    end_of_test();
  end

  // Run should take about 100 us; far beyond that it is hung
  initial begin
    #500000;
    fail_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
